// ### design/gif_pkg.sv
// What this block does
// - Source handshake sends multi-byte messages
// - Acceptor handshake receives multi-byte messages
// - Own talk address under attention: talker
// - Talker sends data or serial-poll status
// - Other talk address under attention: untalk
// - Talk-only mode transmits without addressing
// - Own listen address under attention: listener
// - No listen-only; receive only when addressed
// - Assert service request when attention needed
// - Go-to-local returns local when listener; lockout blocks only local request
// - No parallel poll; ignore its messages
// - No status drive on attention plus EOI
// - Clear on universal, selected only if listener
// - Trigger message acts only when listener
// - No controller function, take-control ignored
// - Honor poll enable/disable, unlisten, untalk, addresses
// - Five-bit bus address compared on commands
// - Message ends on EOI or line feed
package gif_pkg;
	localparam int CLK_MHZ    = 25;
	localparam int SETTLE_NS  = 2000;
	localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
	localparam int SETTLE_W   = 6;
	localparam logic [SETTLE_W-1:0] SETTLE_CNT = SETTLE_W'(SETTLE_CYC);
	localparam logic [SETTLE_W-1:0] SETTLE_ONE = 6'h01;
	localparam int ADDR_W     = 5;
	localparam logic [6:0] CMD_GTL = 7'h01;
	localparam logic [6:0] CMD_SDC = 7'h04;
	localparam logic [6:0] CMD_PPC = 7'h05;
	localparam logic [6:0] CMD_GET = 7'h08;
	localparam logic [6:0] CMD_TCT = 7'h09;
	localparam logic [6:0] CMD_LLO = 7'h11;
	localparam logic [6:0] CMD_DCL = 7'h14;
	localparam logic [6:0] CMD_PPU = 7'h15;
	localparam logic [6:0] CMD_SPE = 7'h18;
	localparam logic [6:0] CMD_SPD = 7'h19;
	localparam logic [6:0] CMD_UNL = 7'h3f;
	localparam logic [6:0] CMD_UNT = 7'h5f;
	localparam logic [1:0] GRP_LISTEN = 2'h1;
	localparam logic [1:0] GRP_TALK   = 2'h2;
	localparam logic [7:0] CHAR_LF    = 8'h0a;
	localparam int RSV_BIT = 6;
	localparam int SY_ATN  = 0;
	localparam int SY_EOI  = 1;
	localparam int SY_DAV  = 2;
	localparam int SY_NRFD = 3;
	localparam int SY_NDAC = 4;
	localparam int SY_IFC  = 5;
	localparam int SY_REN  = 6;
	localparam int SY_DIO  = 7;
	localparam int SY_W    = 15;
	typedef enum logic [3:0] {
		SH_IDLE   = 4'h1,
		SH_WAIT   = 4'h2,
		SH_SETTLE = 4'h4,
		SH_XFER   = 4'h8
	} gif_sh_t;
	typedef enum logic [2:0] {
		AH_IDLE  = 3'h1,
		AH_READY = 3'h2,
		AH_DONE  = 3'h4
	} gif_ah_t;
endpackage : gif_pkg

// ### design/gif_sync.sv
`timescale 1ns/10ps
module gif_sync #(
	parameter int W = 8
) (
	input  wire logic         core_clk,
	input  wire logic         sys_rst,
	input  wire logic         ce,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] stage1_reg;
	logic [W-1:0] stage2_reg;

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			stage1_reg <= '0;
			stage2_reg <= '0;
		end
		else if (ce)
		begin
			stage1_reg <= din;
			stage2_reg <= stage1_reg;
		end
	end

	assign dout = stage2_reg;
endmodule : gif_sync

// ### design/gif_device.sv
`timescale 1ns/10ps
module gif_device (
	input  wire logic                      core_clk,
	input  wire logic                      sys_rst,
	input  wire logic                      ce,
	input  wire logic [7:0]                dioIn,
	output logic      [7:0]                dioOut,
	output logic                           dioOe,
	input  wire logic                      atnIn,
	input  wire logic                      eoiIn,
	output logic                           eoiOut,
	output logic                           eoiOe,
	input  wire logic                      davIn,
	output logic                           davOut,
	output logic                           davOe,
	input  wire logic                      nrfdIn,
	output logic                           nrfdOut,
	output logic                           nrfdOe,
	input  wire logic                      ndacIn,
	output logic                           ndacOut,
	output logic                           ndacOe,
	input  wire logic                      ifcIn,
	input  wire logic                      renIn,
	output logic                           srqOut,
	output logic                           srqOe,
	input  wire logic [gif_pkg::ADDR_W-1:0] devAddr,
	input  wire logic                      talkOnly,
	input  wire logic [7:0]                txData,
	input  wire logic                      txEnd,
	input  wire logic                      txValid,
	output logic                           txTaken,
	input  wire logic [7:0]                statusByte,
	input  wire logic                      serviceReq,
	input  wire logic                      localReq,
	output logic      [7:0]                rxData,
	output logic                           rxEnd,
	output logic                           rxValid,
	output logic                           talker,
	output logic                           listener,
	output logic                           remote,
	output logic                           lockout,
	output logic                           serialPoll,
	output logic                           devClear,
	output logic                           trigger
);
	import gif_pkg::*;

	logic [SY_W-1:0]     syncIn;
	logic [SY_W-1:0]     syncOut;
	logic                atnS;
	logic                eoiS;
	logic                davS;
	logic                nrfdS;
	logic                ndacS;
	logic                ifcS;
	logic                renS;
	logic [7:0]          dioS;
	gif_sh_t             shState_reg;
	gif_ah_t             ahState_reg;
	logic [SETTLE_W-1:0] settle_reg;
	logic [7:0]          dio_reg;
	logic                dioOe_reg;
	logic                srcEnd_reg;
	logic                eoiOe_reg;
	logic                davOe_reg;
	logic                nrfdOe_reg;
	logic                ndacOe_reg;
	logic                txTaken_reg;
	logic                spSent_reg;
	logic [7:0]          rxByte_reg;
	logic                rxEnd_reg;
	logic                rxValid_reg;
	logic                cmdStb_reg;
	logic                talker_reg;
	logic                listener_reg;
	logic                spMode_reg;
	logic                remote_reg;
	logic                lockout_reg;
	logic                devClear_reg;
	logic                trigger_reg;
	logic                srqPend_reg;
	logic                svcPrev_reg;
	logic                srqOe_reg;
	logic [6:0]          cmd;
	logic                isListen;
	logic                isTalkGrp;
	logic                ahActive;

	// Bus lines are asynchronous to core_clk
	assign syncIn = {dioIn, renIn, ifcIn, ndacIn, nrfdIn, davIn, eoiIn, atnIn};
	gif_sync #(.W(SY_W)) uSync (
		.core_clk(core_clk),
		.sys_rst (sys_rst),
		.ce      (ce),
		.din     (syncIn),
		.dout    (syncOut)
	);
	assign atnS  = syncOut[SY_ATN];
	assign eoiS  = syncOut[SY_EOI];
	assign davS  = syncOut[SY_DAV];
	assign nrfdS = syncOut[SY_NRFD];
	assign ndacS = syncOut[SY_NDAC];
	assign ifcS  = syncOut[SY_IFC];
	assign renS  = syncOut[SY_REN];
	assign dioS  = syncOut[SY_DIO+7:SY_DIO];

	// Source handshake; released at once when attention shows
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			shState_reg <= SH_IDLE;
			settle_reg  <= '0;
			dio_reg     <= '0;
			dioOe_reg   <= 1'b0;
			srcEnd_reg  <= 1'b0;
			eoiOe_reg   <= 1'b0;
			davOe_reg   <= 1'b0;
			txTaken_reg <= 1'b0;
			spSent_reg  <= 1'b0;
		end
		else if (ce)
		begin
			txTaken_reg <= 1'b0;
			spSent_reg  <= 1'b0;
			if (atnS || !talker_reg)
			begin
				shState_reg <= SH_IDLE;
				dioOe_reg   <= 1'b0;
				eoiOe_reg   <= 1'b0;
				davOe_reg   <= 1'b0;
			end
			else
			begin
				case (shState_reg)
					SH_IDLE:
					begin
						// Status byte carries the pending request in its rsv bit
						if (spMode_reg)
						begin
							dio_reg     <= statusByte;
							dio_reg[RSV_BIT] <= srqPend_reg;
							srcEnd_reg  <= 1'b0;
							shState_reg <= SH_WAIT;
						end
						else if (txValid && !txTaken_reg)
						begin
							dio_reg     <= txData;
							srcEnd_reg  <= txEnd;
							shState_reg <= SH_WAIT;
						end
					end
					SH_WAIT:
					begin
						if (!nrfdS && ndacS)
						begin
							dioOe_reg   <= 1'b1;
							eoiOe_reg   <= srcEnd_reg;
							settle_reg  <= SETTLE_CNT;
							shState_reg <= SH_SETTLE;
						end
					end
					SH_SETTLE:
					begin
						// Data must settle on the lines before DAV is asserted
						if (settle_reg == SETTLE_ONE)
						begin
							davOe_reg   <= 1'b1;
							shState_reg <= SH_XFER;
						end
						else
						begin
							settle_reg <= settle_reg - SETTLE_ONE;
						end
					end
					SH_XFER:
					begin
						if (!ndacS)
						begin
							davOe_reg   <= 1'b0;
							dioOe_reg   <= 1'b0;
							eoiOe_reg   <= 1'b0;
							txTaken_reg <= !spMode_reg;
							spSent_reg  <= spMode_reg;
							shState_reg <= SH_IDLE;
						end
					end
					default:
					begin
						shState_reg <= SH_IDLE;
					end
				endcase
			end
		end
	end

	// Commands are always accepted; data only while addressed
	assign ahActive = atnS || listener_reg;

	// Acceptor handshake
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			ahState_reg <= AH_IDLE;
			nrfdOe_reg  <= 1'b0;
			ndacOe_reg  <= 1'b0;
			rxByte_reg  <= '0;
			rxEnd_reg   <= 1'b0;
			rxValid_reg <= 1'b0;
			cmdStb_reg  <= 1'b0;
		end
		else if (ce)
		begin
			rxValid_reg <= 1'b0;
			cmdStb_reg  <= 1'b0;
			case (ahState_reg)
				AH_IDLE:
				begin
					if (ahActive && !davS)
					begin
						ndacOe_reg  <= 1'b1;
						nrfdOe_reg  <= 1'b0;
						ahState_reg <= AH_READY;
					end
				end
				AH_READY:
				begin
					if (!ahActive)
					begin
						ndacOe_reg  <= 1'b0;
						nrfdOe_reg  <= 1'b0;
						ahState_reg <= AH_IDLE;
					end
					else if (davS)
					begin
						rxByte_reg  <= dioS;
						rxEnd_reg   <= eoiS || (dioS == CHAR_LF);
						cmdStb_reg  <= atnS;
						rxValid_reg <= !atnS && listener_reg;
						nrfdOe_reg  <= 1'b1;
						ndacOe_reg  <= 1'b0;
						ahState_reg <= AH_DONE;
					end
				end
				AH_DONE:
				begin
					if (!davS)
					begin
						ndacOe_reg  <= 1'b1;
						nrfdOe_reg  <= 1'b0;
						ahState_reg <= AH_READY;
					end
				end
				default:
				begin
					ahState_reg <= AH_IDLE;
				end
			endcase
		end
	end

	// Address match on the seven low bits
	assign cmd       = rxByte_reg[6:0];
	assign isListen  = cmd[6:5] == GRP_LISTEN && cmd[4:0] == devAddr && cmd != CMD_UNL;
	assign isTalkGrp = cmd[6:5] == GRP_TALK && cmd != CMD_UNT;

	// Addressing; parallel poll and take-control codes fall through
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			talker_reg   <= 1'b0;
			listener_reg <= 1'b0;
			spMode_reg   <= 1'b0;
		end
		else if (ce)
		begin
			if (ifcS)
			begin
				talker_reg   <= talkOnly;
				listener_reg <= 1'b0;
				spMode_reg   <= 1'b0;
			end
			else if (talkOnly)
			begin
				talker_reg   <= 1'b1;
				listener_reg <= 1'b0;
			end
			else if (cmdStb_reg)
			begin
				if (cmd == CMD_UNL)
					listener_reg <= 1'b0;
				else if (isListen)
					listener_reg <= 1'b1;
				if (cmd == CMD_UNT)
					talker_reg <= 1'b0;
				else if (isTalkGrp)
					talker_reg <= cmd[4:0] == devAddr;
				if (cmd == CMD_SPE)
					spMode_reg <= 1'b1;
				else if (cmd == CMD_SPD)
					spMode_reg <= 1'b0;
			end
		end
	end

	// Device events
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			devClear_reg <= 1'b0;
			trigger_reg  <= 1'b0;
		end
		else if (ce)
		begin
			devClear_reg <= cmdStb_reg && (cmd == CMD_DCL
				|| (cmd == CMD_SDC && listener_reg));
			trigger_reg  <= cmdStb_reg && cmd == CMD_GET && listener_reg;
		end
	end

	// Remote and lockout; REN low forces local and drops lockout
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			remote_reg  <= 1'b0;
			lockout_reg <= 1'b0;
		end
		else if (ce)
		begin
			if (!renS)
			begin
				remote_reg  <= 1'b0;
				lockout_reg <= 1'b0;
			end
			else
			begin
				if (cmdStb_reg && isListen)
					remote_reg <= 1'b1;
				else if (cmdStb_reg && cmd == CMD_GTL && listener_reg)
					remote_reg <= 1'b0;
				else if (localReq && !lockout_reg)
					remote_reg <= 1'b0;
				if (cmdStb_reg && cmd == CMD_LLO)
					lockout_reg <= 1'b1;
			end
		end
	end

	// Service request; a new request wins over the poll that clears it
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			srqPend_reg <= 1'b0;
			svcPrev_reg <= 1'b0;
			srqOe_reg   <= 1'b0;
		end
		else if (ce)
		begin
			svcPrev_reg <= serviceReq;
			if (serviceReq && !svcPrev_reg)
				srqPend_reg <= 1'b1;
			else if (spSent_reg || !serviceReq)
				srqPend_reg <= 1'b0;
			srqOe_reg <= srqPend_reg;
		end
	end

	// Open-collector lines drive only their asserted level
	assign dioOut     = dio_reg;
	assign dioOe      = dioOe_reg;
	assign eoiOut     = eoiOe_reg;
	assign eoiOe      = eoiOe_reg;
	assign davOut     = davOe_reg;
	assign davOe      = davOe_reg;
	assign nrfdOut    = nrfdOe_reg;
	assign nrfdOe     = nrfdOe_reg;
	assign ndacOut    = ndacOe_reg;
	assign ndacOe     = ndacOe_reg;
	assign srqOut     = srqOe_reg;
	assign srqOe      = srqOe_reg;
	assign txTaken    = txTaken_reg;
	assign rxData     = rxByte_reg;
	assign rxEnd      = rxEnd_reg;
	assign rxValid    = rxValid_reg;
	assign talker     = talker_reg;
	assign listener   = listener_reg;
	assign remote     = remote_reg;
	assign lockout    = lockout_reg;
	assign serialPoll = spMode_reg;
	assign devClear   = devClear_reg;
	assign trigger    = trigger_reg;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	sequence s_cmd(logic [6:0] c);
		ce && cmdStb_reg && !ifcS && !talkOnly && cmd == c;
	endsequence
	sequence s_take;
		ce && ahState_reg == AH_READY && ahActive && davS;
	endsequence

	property p_talk;
		s_cmd({GRP_TALK, devAddr}) |=> talker_reg;
	endproperty
	a_talk: assert property (p_talk) else $error("own talk address ignored");
	property p_untalk;
		ce && cmdStb_reg && !ifcS && !talkOnly && isTalkGrp && cmd[4:0] != devAddr
			|=> !talker_reg;
	endproperty
	a_untalk: assert property (p_untalk) else $error("talker kept on other address");
	property p_listen;
		s_cmd({GRP_LISTEN, devAddr}) |=> listener_reg;
	endproperty
	a_listen: assert property (p_listen) else $error("own listen address ignored");
	property p_noListenOnly;
		ce && talkOnly |=> !listener_reg && talker_reg;
	endproperty
	a_noListenOnly: assert property (p_noListenOnly) else $error("listener in talk-only");
	property p_srq;
		ce && srqPend_reg |=> srqOe_reg;
	endproperty
	a_srq: assert property (p_srq) else $error("service request not driven");
	property p_noEoiOnAtn;
		ce && atnS |=> !eoiOe_reg && !davOe_reg;
	endproperty
	a_noEoiOnAtn: assert property (p_noEoiOnAtn) else $error("drive under attention");
	property p_dcl;
		s_cmd(CMD_DCL) |=> devClear_reg ##1 !devClear_reg || !ce;
	endproperty
	a_dcl: assert property (p_dcl) else $error("device clear missed");
	property p_get;
		ce && cmdStb_reg && cmd == CMD_GET && !listener_reg |=> !trigger_reg;
	endproperty
	a_get: assert property (p_get) else $error("trigger while not listener");
	property p_davHold;
		ce && davOe_reg && ndacS && !atnS && talker_reg |=> davOe_reg;
	endproperty
	a_davHold: assert property (p_davHold) else $error("DAV dropped early");
	property p_take;
		s_take |=> ahState_reg == AH_DONE && nrfdOe_reg && !ndacOe_reg;
	endproperty
	a_take: assert property (p_take) else $error("byte not accepted");
endmodule : gif_device

// ### verification/gif_ctrl_model.sv
`timescale 1ns/10ps
module gif_ctrl_model (
	input  wire logic       core_clk,
	input  wire logic       davBus,
	input  wire logic       nrfdBus,
	input  wire logic       ndacBus,
	input  wire logic       eoiBus,
	input  wire logic [7:0] dioBus,
	output logic            atn,
	output logic            eoi,
	output logic            dav,
	output logic            nrfd,
	output logic            ndac,
	output logic            ifc,
	output logic            ren,
	output logic      [7:0] dio
);
	int errs;
	initial
	begin
		errs = 0;
		{atn, eoi, dav, ifc, ren} = 5'h00;
		{nrfd, ndac} = 2'h3;
		dio = 8'h5a;
	end
	// Bounded wait on one handshake wire, counted as a fault if it never arrives
	task automatic waitBus(input int sel, input logic lvl);
		int n;
		logic v;
		for (n = 0; n < 400; n++)
		begin
			v = (sel == 0) ? nrfdBus : (sel == 1) ? ndacBus : davBus;
			if (v === lvl)
				return;
			@(negedge core_clk);
		end
		errs++;
	endtask : waitBus
	task automatic setLines(input logic r, input logic i, input logic a);
		@(negedge core_clk);
		ren = r;
		ifc = i;
		atn = a;
	endtask : setLines
	// Addresses and commands go out with attention held
	task automatic sendByte(input logic [7:0] b, input logic a, input logic e);
		@(negedge core_clk);
		{nrfd, ndac} = 2'h0;
		atn = a;
		repeat (4) @(negedge core_clk);
		waitBus(0, 1'b0);
		dio = b;
		eoi = e;
		repeat (2) @(negedge core_clk);
		dav = 1'b1;
		@(negedge core_clk);
		waitBus(1, 1'b0);
		dav = 1'b0;
		eoi = 1'b0;
		dio = ~b; // Released lines show a changed pattern, not the old byte
	endtask : sendByte
	task automatic readByte(output logic [7:0] b, output logic e);
		@(negedge core_clk);
		atn = 1'b0;
		ndac = 1'b1;
		nrfd = 1'b0;
		waitBus(2, 1'b1);
		b = dioBus;
		e = eoiBus;
		nrfd = 1'b1;
		ndac = 1'b0;
		waitBus(2, 1'b0);
		ndac = 1'b1;
	endtask : readByte
	task automatic idy(input int n);
		@(negedge core_clk);
		{atn, eoi} = 2'h3;
		repeat (n) @(negedge core_clk);
		eoi = 1'b0;
	endtask : idy
endmodule : gif_ctrl_model

// ### verification/tb_top.sv
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin err_count++; \
	$display("Error %s expected %h seen %h", nm, ex, got); end end
module tb_top;
	import gif_pkg::*;
	localparam logic [4:0] ADDR = 5'h0a;
	logic       core_clk, sys_rst, dioOe, eoiOut, eoiOe, davOut, davOe, nrfdOut, nrfdOe;
	logic       ndacOut, ndacOe, srqOut, srqOe, talkOnly, txEnd, txValid, txTaken;
	logic       serviceReq, localReq, rxEnd, rxValid, talker, listener, remote, lockout;
	logic       serialPoll, devClear, trigger, mAtn, mEoi, mDav, mNrfd, mNdac, mIfc, mRen;
	logic       davBus, nrfdBus, ndacBus, eoiBus, rxEndLast, e;
	logic [7:0] dioOut, txData, statusByte, rxData, mDio, dioBus, rxLast, b;
	int         err_count, check_count, rxCnt, trgCnt, clrCnt, tkCnt, drv, watch;
	assign davBus  = (davOe & davOut) | mDav;
	assign nrfdBus = (nrfdOe & nrfdOut) | mNrfd;
	assign ndacBus = (ndacOe & ndacOut) | mNdac;
	assign eoiBus  = (eoiOe & eoiOut) | mEoi;
	assign dioBus  = dioOe ? dioOut : mDio;
	gif_ctrl_model ctl (.core_clk(core_clk), .davBus(davBus), .nrfdBus(nrfdBus),
		.ndacBus(ndacBus), .eoiBus(eoiBus), .dioBus(dioBus), .atn(mAtn), .eoi(mEoi),
		.dav(mDav), .nrfd(mNrfd), .ndac(mNdac), .ifc(mIfc), .ren(mRen), .dio(mDio));
	gif_device dut (.core_clk(core_clk), .sys_rst(sys_rst), .ce(1'b1), .dioIn(dioBus),
		.dioOut(dioOut), .dioOe(dioOe), .atnIn(mAtn), .eoiIn(eoiBus), .eoiOut(eoiOut),
		.eoiOe(eoiOe), .davIn(davBus), .davOut(davOut), .davOe(davOe), .nrfdIn(nrfdBus),
		.nrfdOut(nrfdOut), .nrfdOe(nrfdOe), .ndacIn(ndacBus), .ndacOut(ndacOut),
		.ndacOe(ndacOe), .ifcIn(mIfc), .renIn(mRen), .srqOut(srqOut), .srqOe(srqOe),
		.devAddr(ADDR), .talkOnly(talkOnly), .txData(txData), .txEnd(txEnd),
		.txValid(txValid), .txTaken(txTaken), .statusByte(statusByte),
		.serviceReq(serviceReq), .localReq(localReq), .rxData(rxData), .rxEnd(rxEnd),
		.rxValid(rxValid), .talker(talker), .listener(listener), .remote(remote),
		.lockout(lockout), .serialPoll(serialPoll), .devClear(devClear), .trigger(trigger));
	always #20 core_clk = ~core_clk;
	// Pulses are counted here so that no scenario can miss a one-cycle output
	always @(posedge core_clk)
	begin
		if (rxValid === 1'b1)
		begin
			rxCnt++;
			rxLast = rxData;
			rxEndLast = rxEnd;
		end
		trgCnt += (trigger === 1'b1);
		clrCnt += (devClear === 1'b1);
		tkCnt += (txTaken === 1'b1);
		drv += (watch == 1 && dioOe === 1'b1) || (watch == 2 && (ndacOe | nrfdOe) === 1'b1);
	end
	task test_done;
		$display("Checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : test_done
	task cmd(input logic [6:0] c);
		ctl.sendByte({1'b0, c}, 1'b1, 1'b0);
		repeat (2) @(negedge core_clk);
	endtask : cmd
	// Data byte with attention low; the wait lets the one-cycle pulses reach the counters
	task dat(input logic [7:0] d, input logic en);
		ctl.sendByte(d, 1'b0, en);
		repeat (2) @(negedge core_clk);
	endtask : dat
	task t_listen;
		ctl.setLines(1'b1, 1'b0, 1'b0);
		cmd(7'h2a);
		`CHK("listener", 1'b1, listener)
		`CHK("remote", 1'b1, remote)
		dat(8'h41, 1'b0);
		dat(CHAR_LF, 1'b0);
		`CHK("rx count", 2, rxCnt)
		`CHK("rx lf end", 9'h10a, {rxEndLast, rxLast})
		dat(8'h42, 1'b1);
		`CHK("rx eoi end", 9'h142, {rxEndLast, rxLast})
	endtask : t_listen
	task t_cmds;
		cmd(CMD_GET);
		`CHK("trigger listener", 1, trgCnt)
		cmd(CMD_SDC);
		`CHK("sdc listener", 1, clrCnt)
		cmd(CMD_PPC);
		cmd(CMD_PPU);
		cmd(CMD_TCT);
		`CHK("pp tct ignored", 2'h1, {talker, listener})
		cmd(CMD_UNL);
		`CHK("unlisten", 1'b0, listener)
		cmd(CMD_GET);
		cmd(CMD_SDC);
		`CHK("unaddressed get sdc", 3'h3, {trgCnt[1:0], clrCnt[0]})
		cmd(CMD_DCL);
		`CHK("dcl", 2, clrCnt)
		cmd(7'h2b);
		`CHK("other listen addr", 1'b0, listener)
		ctl.setLines(1'b1, 1'b0, 1'b0);
		repeat (6) @(negedge core_clk);
		watch = 2;
		dat(8'h55, 1'b0);
		watch = 0;
		`CHK("no listen only", 3, rxCnt + drv)
	endtask : t_cmds
	task t_remote;
		cmd(7'h2a);
		cmd(CMD_LLO);
		`CHK("lockout", 2'h3, {lockout, remote})
		localReq = 1'b1;
		repeat (6) @(negedge core_clk);
		localReq = 1'b0;
		`CHK("locked remote", 1'b1, remote)
		cmd(CMD_GTL);
		`CHK("gtl local", 1'b0, remote)
		ctl.setLines(1'b0, 1'b0, 1'b1);
		repeat (6) @(negedge core_clk);
		`CHK("ren off", 1'b0, lockout)
		ctl.setLines(1'b1, 1'b0, 1'b1);
		cmd(7'h2a);
		localReq = 1'b1;
		repeat (2) @(negedge core_clk);
		localReq = 1'b0;
		`CHK("unlocked local", 1'b0, remote)
		cmd(CMD_UNL);
	endtask : t_remote
	task t_poll;
		statusByte = 8'h05;
		serviceReq = 1'b1;
		repeat (4) @(negedge core_clk);
		`CHK("srq", 1'b1, srqOe)
		cmd(7'h4a);
		`CHK("talker", 1'b1, talker)
		cmd(CMD_SPE);
		`CHK("spe", 1'b1, serialPoll)
		// Addressed talker with a status byte ready must still keep off the lines
		watch = 1;
		ctl.idy(20);
		watch = 0;
		`CHK("idy no drive", 0, drv)
		ctl.readByte(b, e);
		`CHK("status byte", 8'h45, b)
		repeat (4) @(negedge core_clk);
		`CHK("srq cleared", 1'b0, srqOe)
		cmd(CMD_SPD);
		`CHK("spd", 1'b0, serialPoll)
		serviceReq = 1'b0;
	endtask : t_poll
	task t_talk;
		txData = 8'h5a;
		txEnd = 1'b0;
		txValid = 1'b1;
		ctl.readByte(b, e);
		`CHK("tx byte 1", 9'h05a, {e, b})
		txData = 8'ha5;
		txEnd = 1'b1;
		ctl.readByte(b, e);
		txValid = 1'b0;
		`CHK("tx byte 2", 9'h1a5, {e, b})
		repeat (2) @(negedge core_clk);
		`CHK("taken count", 2, tkCnt)
		cmd(7'h4b);
		`CHK("other talk addr", 1'b0, talker)
	endtask : t_talk
	task t_talkonly;
		talkOnly = 1'b1;
		txData = 8'h33;
		txEnd = 1'b0;
		txValid = 1'b1;
		repeat (4) @(negedge core_clk);
		`CHK("talk only state", 2'h2, {talker, listener})
		ctl.readByte(b, e);
		txValid = 1'b0;
		`CHK("talk only byte", 8'h33, b)
		talkOnly = 1'b0;
		ctl.setLines(1'b1, 1'b1, 1'b0);
		repeat (4) @(negedge core_clk);
		`CHK("ifc drops talker", 1'b0, talker)
		ctl.setLines(1'b1, 1'b0, 1'b0);
	endtask : t_talkonly
	initial
	begin
		{core_clk, sys_rst, talkOnly, txEnd, txValid, serviceReq, localReq} = 7'h20;
		{txData, statusByte} = 16'h0000;
		{err_count, check_count, rxCnt, trgCnt, clrCnt, tkCnt, drv, watch} = '0;
		repeat (20) @(negedge core_clk);
		sys_rst = 1'b0;
		@(negedge core_clk);
		`CHK("reset state", 3'h0, {talker, listener, remote})
		t_listen;
		t_cmds;
		t_remote;
		t_poll;
		t_talk;
		t_talkonly;
		`CHK("model waits", 0, ctl.errs)
		test_done;
	end
	// Whole run is well under a thousand cycles; this only trips on a hang
	initial
	begin
		repeat (40000) @(posedge core_clk);
		err_count++;
		test_done;
	end
endmodule : tb_top
